/* hdl/pic_ctrl.sv */
// Reset, initialisation and configuration loader of the I/O controller
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
`include "pic_params.svh"
module pic_ctrl
  import pic_pkg::*;
#(
  parameter int LOW_LIMIT = `PIC_IOCLK_LOW_LIMIT
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        phi1,
  input  wire logic        phi2,
  input  wire logic        io_clock,
  input  wire logic        io_input,
  input  wire logic [15:0] pdata,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [3:0]  phase_q,
  output logic             initialized_q,
  output logic             ext_flags_q,
  output logic             ext_regs_q,
  output logic             neg_polarity_q,
  output logic      [5:0]  dev_code_q,
  output logic      [15:0] data_in_q
);
  // Elaboration check: the 8-bit low counter must reach the limit plus one
  if (LOW_LIMIT < 1 || LOW_LIMIT > 250) begin : g_bad_limit
    $error("LOW_LIMIT range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: two flops before any logic reads them
  logic [1:0]  phi1_s_q;         // Phase one sync chain
  logic [1:0]  phi2_s_q;         // Phase two sync chain
  logic [1:0]  ioclk_s_q;        // IO clock sync chain
  logic [1:0]  ioin_s_q;         // Direction sync chain
  logic [15:0] pd_a_q;           // Data first stage
  logic [15:0] pd_b_q;           // Data second stage
  logic        phi1_old_q;       // Previous synced phase one
  logic        phi2_old_q;       // Previous synced phase two

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phi1_s_q  <= 2'h0;
      phi2_s_q  <= 2'h0;
      ioclk_s_q <= 2'h3;
      ioin_s_q  <= 2'h0;
      pd_a_q    <= 16'h0000;
      pd_b_q    <= 16'h0000;
      phi1_old_q <= 1'b0;
      phi2_old_q <= 1'b0;
    end else begin
      phi1_s_q  <= {phi1_s_q[0], phi1};
      phi2_s_q  <= {phi2_s_q[0], phi2};
      ioclk_s_q <= {ioclk_s_q[0], io_clock};
      ioin_s_q  <= {ioin_s_q[0], io_input};
      pd_a_q    <= pdata;
      pd_b_q    <= pd_a_q;
      phi1_old_q <= phi1_s_q[1];
      phi2_old_q <= phi2_s_q[1];
    end
  end

  // Master-clock edges seen on either phase; only a phase one rise gives a tick
  wire phi1_rise = phi1_s_q[1] & ~phi1_old_q;
  wire phi2_rise = phi2_s_q[1] & ~phi2_old_q;
  wire mclk_tick = phi1_rise;
  wire ioclk_low = ~ioclk_s_q[1];
  wire receiving = ioin_s_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  wire        wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        wb_wr     = wb_req & wb_we_i & wb_sel_i[0];
  wire        hit_ctrl  = (wb_adr_i == `PIC_REG_ADDR_CTRL);
  wire        hit_cfg   = (wb_adr_i == `PIC_REG_ADDR_CFG);
  wire        hit_stat  = (wb_adr_i == `PIC_REG_ADDR_STATUS);
  wire        hit_mem   = (wb_adr_i == `PIC_REG_ADDR_MEMDATA);
  wire        ctrl_wr   = wb_wr & hit_ctrl;
  wire        sw_reset  = ctrl_wr & wb_dat_i[`PIC_CTRL_SW_RESET_BIT];
  wire        req_en    = ctrl_wr & wb_dat_i[`PIC_CTRL_REQ_EN_BIT];
  wire        io_reset  = ctrl_wr & wb_dat_i[`PIC_CTRL_IO_RESET_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  pic_state_t state_q;            // Current state
  pic_state_t state_d;            // Next state
  logic [7:0] low_cnt_q;          // IO clock low length in master cycles
  logic [1:0] req_cnt_q;          // Request enables seen in reset
  pic_cfg_t   cfg_q;              // Latched configuration word
  logic       pol_q;              // Polarity in force
  pic_flags_t flags_q;            // Internal flags

  wire low_too_long = (low_cnt_q > 8'(LOW_LIMIT));
  // A long low line resets only while receiving; transmit-side low is illegal
  wire bus_reset = (state_q == PIC_ST_RUN) & low_too_long & receiving;
  wire load_cfg  = (state_q == PIC_ST_INIT);
  // Reset-state request enables; the second one starts initialisation
  wire second_re = req_en & (state_q == PIC_ST_ARMED);

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PIC_ST_RESET: if (req_en) state_d = PIC_ST_ARMED;
      PIC_ST_ARMED: if (req_en) state_d = PIC_ST_INIT;
      PIC_ST_INIT:  state_d = PIC_ST_RUN;
      PIC_ST_RUN: begin
        if (bus_reset || sw_reset) state_d = PIC_ST_RESET;
        else if (io_reset) state_d = PIC_ST_INIT;
      end
    endcase
  end

  // State register; asynchronous reset lands in cleared reset state
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) state_q <= PIC_ST_RESET;
    else          state_q <= state_d;
  end

  // Count master cycles with IO clock held low while running
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)                           low_cnt_q <= 8'h00;
    else if (!ioclk_low || state_q != PIC_ST_RUN) low_cnt_q <= 8'h00;
    else if (mclk_tick && !low_too_long)    low_cnt_q <= low_cnt_q + 8'h01;
  end

  // Request enables seen while reset, for status
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)                 req_cnt_q <= 2'h0;
    else if (state_q == PIC_ST_RUN) req_cnt_q <= 2'h0;
    else if (req_en && req_cnt_q != 2'(`PIC_REQ_EN_COUNT)) begin
      req_cnt_q <= req_cnt_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration latch and polarity hand-over
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= `PIC_CFG_RESET;
      pol_q <= 1'b0;
    end else begin
      if (load_cfg) begin
        cfg_q.ext_flags    <= ~pd_b_q[`PIC_EXT_FLAG_BIT];
        cfg_q.ext_regs     <= ~pd_b_q[`PIC_EXT_REG_BIT];
        cfg_q.neg_polarity <= pd_b_q[`PIC_POLARITY_BIT];
        // Negative logic: high on a line reads as zero
        cfg_q.dev_code <= ~pd_b_q[`PIC_DEVCODE_MSB:`PIC_DEVCODE_LSB];
      end
      // Old polarity holds through the load; new one one cycle later
      if (state_q == PIC_ST_RUN) pol_q <= cfg_q.neg_polarity;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags cleared by any initialisation or reset entry
  wire clear_all = load_cfg | (state_q == PIC_ST_RESET);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)       flags_q <= '0;
    else if (clear_all) flags_q <= '0;
  end

  // Word count and address registers
  logic [15:0] mem_rdata;
  wire         mem_we = wb_wr & hit_mem & (state_q == PIC_ST_RUN);
  pic_mem #(.WIDTH(16), .DEPTH(2)) u_mem (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clr     (clear_all),
    .we      (mem_we),
    .addr    (wb_dat_i[16]),
    .wdata   (wb_dat_i[15:0]),
    .rdata   (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Four-phase clock from the phi pair, held at zero while not running
  wire clk_run = (state_q == PIC_ST_RUN);
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)     phase_q <= 4'h0;
    else if (!clk_run) phase_q <= 4'h0;
    else if (phi1_rise) phase_q <= 4'h1;
    else if (phi1_s_q[1] == 1'b0 && phi1_old_q) phase_q <= 4'h2;
    else if (phi2_rise) phase_q <= 4'h4;
    else if (phi2_s_q[1] == 1'b0 && phi2_old_q) phase_q <= 4'h8;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  wire [31:0] rd_mux =
    hit_cfg  ? {23'h0, cfg_q} :
    hit_stat ? {20'h0, req_cnt_q, state_q, flags_q, pol_q, 3'h0} :
    hit_mem  ? {16'h0, mem_rdata} : 32'h0000_0000;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o       <= 1'b0;
      wb_dat_o       <= 32'h0000_0000;
      initialized_q  <= 1'b0;
      ext_flags_q    <= 1'b0;
      ext_regs_q     <= 1'b0;
      neg_polarity_q <= 1'b0;
      dev_code_q     <= 6'h00;
      data_in_q      <= 16'h0000;
    end else begin
      wb_ack_o       <= wb_req;
      wb_dat_o       <= (wb_req && !wb_we_i) ? rd_mux : 32'h0000_0000;
      initialized_q  <= clk_run;
      ext_flags_q    <= cfg_q.ext_flags;
      ext_regs_q     <= cfg_q.ext_regs;
      neg_polarity_q <= pol_q;
      dev_code_q     <= cfg_q.dev_code;
      // Data presented in the polarity in force
      data_in_q      <= pol_q ? ~pd_b_q : pd_b_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_power_up;
    @(posedge sys_clk) $rose(reset_n) |-> state_q == PIC_ST_RESET;
  endproperty
  a_power_up: assert property (p_power_up) else $error("not in reset");

  property p_halt;
    @(posedge sys_clk) disable iff (!reset_n)
      state_q == PIC_ST_RESET |=> phase_q == 4'h0;
  endproperty
  a_halt: assert property (p_halt) else $error("phase ran in reset");

  property p_bus_reset;
    @(posedge sys_clk) disable iff (!reset_n)
      bus_reset |=> state_q == PIC_ST_RESET;
  endproperty
  a_bus_reset: assert property (p_bus_reset)
    else $error("no bus reset");

  property p_init_run;
    @(posedge sys_clk) disable iff (!reset_n)
      state_q == PIC_ST_INIT |=> clk_run ##1 initialized_q;
  endproperty
  a_init_run: assert property (p_init_run)
    else $error("clock not started");

  property p_clear;
    @(posedge sys_clk) disable iff (!reset_n)
      load_cfg |=> flags_q == '0 ##1 mem_rdata == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("not cleared");

  property p_two_re;
    @(posedge sys_clk) disable iff (!reset_n)
      second_re |=> state_q == PIC_ST_INIT;
  endproperty
  a_two_re: assert property (p_two_re) else $error("no init");

  property p_io_reset;
    @(posedge sys_clk) disable iff (!reset_n)
      (state_q == PIC_ST_RUN && io_reset && !bus_reset && !sw_reset)
        |=> load_cfg;
  endproperty
  a_io_reset: assert property (p_io_reset) else $error("no reload");

  property p_devcode;
    @(posedge sys_clk) disable iff (!reset_n)
      load_cfg |=> cfg_q.dev_code == ~$past(pd_b_q[15:10]);
  endproperty
  a_devcode: assert property (p_devcode) else $error("bad code");

  property p_pol_hold;
    @(posedge sys_clk) disable iff (!reset_n)
      load_cfg |=> pol_q == $past(pol_q);
  endproperty
  a_pol_hold: assert property (p_pol_hold)
    else $error("early polarity");

  property p_ext_flags;
    @(posedge sys_clk) disable iff (!reset_n)
      load_cfg |=> cfg_q.ext_flags == !$past(pd_b_q[7])
        ##1 ext_flags_q == cfg_q.ext_flags;
  endproperty
  a_ext_flags: assert property (p_ext_flags)
    else $error("bad flag sel");

  c_init: cover property (@(posedge sys_clk) second_re);
  c_bus_rst: cover property (@(posedge sys_clk) bus_reset);
  c_io_rst: cover property (@(posedge sys_clk) io_reset && clk_run);
endmodule

/* common/pic_params.svh */
// Constants for the reset and initialisation block of the I/O controller
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH
`define PIC_IOCLK_LOW_LIMIT      8
`define PIC_EXT_FLAG_BIT         7
`define PIC_EXT_REG_BIT          8
`define PIC_POLARITY_BIT         9
`define PIC_DEVCODE_LSB          10
`define PIC_DEVCODE_MSB          15
`define PIC_REQ_EN_COUNT         2
`define PIC_CFG_RESET            9'h000
`define PIC_REG_ADDR_CFG         32'h0000_0000
`define PIC_REG_ADDR_STATUS      32'h0000_0004
`define PIC_REG_ADDR_CTRL        32'h0000_0008
`define PIC_REG_ADDR_MEMDATA     32'h0000_000C
`define PIC_CTRL_SW_RESET_BIT    0
`define PIC_CTRL_REQ_EN_BIT      1
`define PIC_CTRL_IO_RESET_BIT    2
`endif

/* common/pic_pkg.sv */
// Types shared by the reset and initialisation block
package pic_pkg;
  typedef enum logic [1:0] {
    PIC_ST_RESET = 2'b00,
    PIC_ST_ARMED = 2'b01,
    PIC_ST_INIT  = 2'b10,
    PIC_ST_RUN   = 2'b11
  } pic_state_t;
  typedef struct packed {
    logic       ext_flags;
    logic       ext_regs;
    logic       neg_polarity;
    logic [5:0] dev_code;
  } pic_cfg_t;
  typedef struct packed {
    logic int_disable;
    logic dch_request;
    logic busy;
    logic done;
  } pic_flags_t;
endpackage

/* hdl/pic_mem.sv */
// Small memory holding the word count and address registers
`timescale 1ns/1ns
module pic_mem
  import pic_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  input  wire logic                     clr,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  input  wire logic [WIDTH-1:0]         wdata,
  output logic      [WIDTH-1:0]         rdata
);
  // Elaboration check: depth must fill the address width exactly
  if (DEPTH < 2 || WIDTH < 1 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_size
    $error("pic_mem bad size");
  end
  // Storage words
  logic [WIDTH-1:0] mem_q [DEPTH];
  // Clear is a whole-array wipe, so storage stays in flops not RAM
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
      rdata <= '0;
    end else if (clr) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
      rdata <= '0;
    end else begin
      if (we) mem_q[addr] <= wdata;
      rdata <= mem_q[addr];
    end
  end
endmodule

/* sim/pic_cpu_model.sv */
// Behavioural model of the CPU serial bus side and the peripheral lines
`timescale 1ns/1ns
module pic_cpu_model (
  input  wire logic        hold_low,
  input  wire logic        transmit,
  input  wire logic [15:0] cfg_word,
  output logic             phi1,
  output logic             phi2,
  output logic             io_clock,
  output logic             io_input,
  output logic      [15:0] pdata
);
  // Free-running non-overlapping phase pair, 320 ns a cycle
  initial begin
    phi1 = 1'b0;
    phi2 = 1'b0;
    forever begin
      #40 phi1 = 1'b1;
      #120 phi1 = 1'b0;
      #40 phi2 = 1'b1;
      #120 phi2 = 1'b0;
    end
  end
  // Direction line is high while the block receives
  assign io_input = ~transmit;
  // Clock line is never held low while the block transmits
  assign io_clock = ~(hold_low & ~transmit);
  // Peripheral keeps its strap word on the data lines
  assign pdata = cfg_word;
endmodule

/* sim/testbench.sv */
// Self-checking bench for the reset and initialisation block
`timescale 1ns/1ns
`include "pic_params.svh"
module testbench import pic_pkg::*;;
  // One table row: strap word, expected config, expected data after polarity
  typedef struct packed {
    logic [15:0] pd;
    pic_cfg_t    cfg;
    logic [15:0] din;
  } pic_row_t;
  logic        sys_clk, reset_n, hold_low, transmit;
  logic [15:0] cfg_word, pdata, data_in_q;
  logic        phi1, phi2, io_clock, io_input;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
  logic [3:0]  wb_sel_i, phase_q, seen;
  logic        wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic        initialized_q, ext_flags_q, ext_regs_q, neg_polarity_q;
  logic [5:0]  dev_code_q;
  int          fails, comparisons, i;
  pic_row_t    rows [4];
  //////////////////////////////////////////////////////////////////////////
  pic_cpu_model cpu (.hold_low(hold_low), .transmit(transmit),
    .cfg_word(cfg_word), .phi1(phi1), .phi2(phi2), .io_clock(io_clock),
    .io_input(io_input), .pdata(pdata));
  pic_ctrl #(.LOW_LIMIT(8)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
    .phi1(phi1), .phi2(phi2), .io_clock(io_clock), .io_input(io_input),
    .pdata(pdata), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .phase_q(phase_q), .initialized_q(initialized_q),
    .ext_flags_q(ext_flags_q), .ext_regs_q(ext_regs_q),
    .neg_polarity_q(neg_polarity_q), .dev_code_q(dev_code_q),
    .data_in_q(data_in_q));
  //////////////////////////////////////////////////////////////////////////
  // 25 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Print counts and verdict, then stop
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Compare one value, four-state exact
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic single Wishbone cycle; held until ack is sampled high
  task wb(input logic [31:0] a, input logic [31:0] d, input logic w);
    int n;
    @(posedge sys_clk);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i  <= w;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) check(32'h0000_0000, 32'h0000_0001);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask
  // Bounded wait for the initialised flag to reach a level
  task wait_init(input logic v);
    int n;
    n = 0;
    while (initialized_q !== v && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    check(initialized_q, v);
  endtask
  // Two request enables, as a halted CPU keeps issuing them
  task init_seq;
    wb(`PIC_REG_ADDR_CTRL, 32'h0000_0002, 1'b1);
    wb(`PIC_REG_ADDR_CTRL, 32'h0000_0002, 1'b1);
    wait_init(1'b1);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the expected run length
  initial begin
    #2_000_000;
    fails++;
    close_out();
  end
  // Main sequence
  initial begin
    rows[0] = '{16'h0000, 9'h1BF, 16'h0000};
    rows[1] = '{16'hFFFF, 9'h040, 16'h0000};
    rows[2] = '{16'h0280, 9'h0FF, 16'hFD7F};
    rows[3] = '{16'h5500, 9'h12A, 16'h5500};
    fails = 0;
    comparisons = 0;
    reset_n = 1'b0;
    hold_low = 1'b0;
    transmit = 1'b0;
    cfg_word = 16'h0280;
    wb_adr_i = 32'h0000_0000;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'hF;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    // Cleared state after power, internal phases halted
    repeat (16) @(posedge sys_clk);
    check(initialized_q, 1'b0);
    check(phase_q, 4'h0);
    check(neg_polarity_q, 1'b0);
    wb(`PIC_REG_ADDR_STATUS, 32'h0000_0000, 1'b0);
    check(rd[11:0], 12'h000);
    wb(32'h0000_0010, 32'h0000_0000, 1'b0);
    check(rd, 32'h0000_0000);
    $display("test reset done");
    // One request enable arms only; the second initialises
    wb(`PIC_REG_ADDR_CTRL, 32'h0000_0002, 1'b1);
    wb(`PIC_REG_ADDR_STATUS, 32'h0000_0000, 1'b0);
    check(rd[9:8], 2'd1);
    check(initialized_q, 1'b0);
    wb(`PIC_REG_ADDR_CTRL, 32'h0000_0002, 1'b1);
    wait_init(1'b1);
    wb(`PIC_REG_ADDR_STATUS, 32'h0000_0000, 1'b0);
    check(rd[9:8], 2'd3);
    check(rd[7:4], 4'h0);
    seen = 4'h0;
    repeat (16) begin
      @(posedge sys_clk);
      seen = seen | phase_q;
    end
    check(seen, 4'hF);
    check($onehot(phase_q), 1'b1);
    $display("test request enable done");
    // Table of strap words through a forced reset and initialisation
    for (i = 0; i < 4; i++) begin
      cfg_word <= rows[i].pd;
      wb(`PIC_REG_ADDR_CTRL, 32'h0000_0001, 1'b1);
      wait_init(1'b0);
      repeat (4) @(posedge sys_clk);
      init_seq();
      repeat (4) @(posedge sys_clk);
      wb(`PIC_REG_ADDR_CFG, 32'h0000_0000, 1'b0);
      check(rd[8:0], rows[i].cfg);
      check(ext_flags_q, rows[i].cfg.ext_flags);
      check(ext_regs_q, rows[i].cfg.ext_regs);
      check(dev_code_q, rows[i].cfg.dev_code);
      check(neg_polarity_q, rows[i].cfg.neg_polarity);
      check(data_in_q, rows[i].din);
      $display("test row %0d done", i);
    end
    // I/O reset while running clears registers and reloads config
    wb(`PIC_REG_ADDR_MEMDATA, 32'h0000_1234, 1'b1);
    wb(`PIC_REG_ADDR_MEMDATA, 32'h0000_0000, 1'b0);
    check(rd[15:0], 16'h1234);
    cfg_word <= 16'hFFFF;
    repeat (4) @(posedge sys_clk);
    wb(`PIC_REG_ADDR_CTRL, 32'h0000_0004, 1'b1);
    repeat (8) @(posedge sys_clk);
    check(initialized_q, 1'b1);
    wb(`PIC_REG_ADDR_CFG, 32'h0000_0000, 1'b0);
    check(rd[8:0], 9'h040);
    wb(`PIC_REG_ADDR_MEMDATA, 32'h0000_0000, 1'b0);
    check(rd[15:0], 16'h0000);
    wb(`PIC_REG_ADDR_STATUS, 32'h0000_0000, 1'b0);
    check(rd[7:4], 4'h0);
    check(data_in_q, 16'h0000);
    $display("test io reset done");
    // Clock line low during reception: short hold survives, long resets
    hold_low <= 1'b1;
    repeat (40) @(posedge sys_clk);
    hold_low <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check(initialized_q, 1'b1);
    hold_low <= 1'b1;
    repeat (96) @(posedge sys_clk);
    hold_low <= 1'b0;
    check(initialized_q, 1'b0);
    repeat (4) @(posedge sys_clk);
    check(phase_q, 4'h0);
    $display("test bus clock hold done");
    // Reset pulled in mid-run: back to the cleared state
    init_seq();
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(initialized_q, 1'b0);
    check(phase_q, 4'h0);
    check(dev_code_q, 6'h00);
    wb(`PIC_REG_ADDR_STATUS, 32'h0000_0000, 1'b0);
    check(rd[11:0], 12'h000);
    $display("test mid-run reset done");
    close_out();
  end
endmodule
